// ### logic/basic_up_timer.sv
// Local design decision: the strobed register port.
`timescale 1ns/100ps
module basic_up_timer import basic_up_timer_pkg::*; #(
  parameter int unsigned W = 16  // counter, limit and divider width
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // slave mode controller
  input wire logic slave_update,
  input wire logic trigger_start,
  // event outputs
  output logic irq,
  output logic dma_request,
  output logic trigger_output
);

  // ****************************************************************
  // control and state registers
  // ****************************************************************
  logic counter_enable_q;       // counting runs while set
  logic update_disable_q;       // blocks every update event
  logic update_request_source_q;  // only wraps request irq or dma
  logic single_pulse_enable_q;  // stop at next update
  logic reload_buffer_enable_q;  // limit goes through shadow
  logic [2:0] master_output_select_q;  // trigger source choice
  logic update_irq_enable_q;    // gates the update interrupt
  logic update_dma_enable_q;    // gates the update dma request
  logic update_flag_q;          // sticky update flag
  logic [W-1:0] count_value_q;  // the counter itself
  logic [W-1:0] div_count_q;    // divider position
  logic [W-1:0] divider_buf_q;  // software copy of the divider
  logic [W-1:0] divider_act_q;  // copy that the divider uses
  logic [W-1:0] wrap_buf_q;     // software copy of the limit
  logic [W-1:0] wrap_shadow_q;  // copy loaded on update
  logic [IRQ_W-1:0] irq_status_q;  // sticky events
  logic [IRQ_W-1:0] irq_mask_q;    // event mask

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic wr_ctrl1, wr_ctrl2, wr_dien, wr_flags, wr_ceg;  // per-register write strobes
  logic wr_mask, wr_count, wr_div, wr_wrap, rd_irq_status;  // status read clears

  // one strobe per offset; unmapped writes fall through to nothing
  assign wr_ctrl1 = reg_write && (reg_addr == OFS_CONTROL_ONE);
  assign wr_ctrl2 = reg_write && (reg_addr == OFS_CONTROL_TWO);
  assign wr_dien = reg_write && (reg_addr == OFS_DMA_IRQ_EN);
  assign wr_flags = reg_write && (reg_addr == OFS_FLAGS);
  assign wr_ceg = reg_write && (reg_addr == OFS_EVENT_GEN);
  assign wr_mask = reg_write && (reg_addr == OFS_IRQ_MASK);
  assign wr_count = reg_write && (reg_addr == OFS_COUNT);
  assign wr_div = reg_write && (reg_addr == OFS_DIVIDER);
  assign wr_wrap = reg_write && (reg_addr == OFS_WRAP);
  assign rd_irq_status = reg_read && (reg_addr == OFS_IRQ_STATUS);

  // ****************************************************************
  // timebase combinational terms
  // ****************************************************************
  logic [W-1:0] wrap_eff;   // limit compared against the count
  logic tick;               // divided clock pulse
  logic wrap;               // count meets the limit on a tick
  logic ug_fire;            // software update generate
  logic update_event;       // update that reaches the shadows
  logic reinit;             // counter and divider restart
  logic update_req;         // update allowed to raise irq or dma

  // without buffering the written limit acts at once
  assign wrap_eff = reload_buffer_enable_q ? wrap_shadow_q : wrap_buf_q;
  // the divider only runs while the counter is enabled
  assign tick = counter_enable_q && (div_count_q == divider_act_q);
  assign wrap = tick && (count_value_q == wrap_eff);
  assign ug_fire = wr_ceg && reg_wdata[BIT_UPDATE_GENERATE];
  // update disable masks all three sources
  assign update_event = !update_disable_q && (wrap || ug_fire || slave_update);
  assign reinit = !update_disable_q && (ug_fire || slave_update);
  // source select keeps generate and slave updates quiet
  assign update_req = update_event && (!update_request_source_q || wrap);

  // ****************************************************************
  // control register one
  // ****************************************************************
  // counter enable: a hardware start wins over any clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counter_enable_q <= 1'b0;
    end else if (trigger_start) begin
      counter_enable_q <= 1'b1;
    end else if (wr_ctrl1) begin
      counter_enable_q <= reg_wdata[BIT_COUNTER_ENABLE];
    end else if (update_event && single_pulse_enable_q) begin
      counter_enable_q <= 1'b0;
    end
  end

  // remaining mode bits are plain storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      update_disable_q <= 1'b0;
      update_request_source_q <= 1'b0;
      single_pulse_enable_q <= 1'b0;
      reload_buffer_enable_q <= 1'b0;
    end else if (wr_ctrl1) begin
      update_disable_q <= reg_wdata[BIT_UPDATE_DISABLE];
      update_request_source_q <= reg_wdata[BIT_UPDATE_SOURCE];
      single_pulse_enable_q <= reg_wdata[BIT_SINGLE_PULSE];
      reload_buffer_enable_q <= reg_wdata[BIT_RELOAD_BUFFER];
    end
  end

  // ****************************************************************
  // control register two and enables
  // ****************************************************************
  // master output select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      master_output_select_q <= MMS_RESET;
    end else if (wr_ctrl2) begin
      master_output_select_q <= reg_wdata[MMS_MSB:MMS_LSB];
    end
  end

  // dma and interrupt enables
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      update_irq_enable_q <= 1'b0;
      update_dma_enable_q <= 1'b0;
    end else if (wr_dien) begin
      update_irq_enable_q <= reg_wdata[BIT_UPDATE_IRQ_EN];
      update_dma_enable_q <= reg_wdata[BIT_UPDATE_DMA_EN];
    end
  end

  // ****************************************************************
  // update flag
  // ****************************************************************
  // writing one leaves the flag alone; a new update request beats the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      update_flag_q <= 1'b0;
    end else if (update_req) begin
      update_flag_q <= 1'b1;
    end else if (wr_flags && !reg_wdata[BIT_UPDATE_FLAG]) begin
      update_flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // divider and counter
  // ****************************************************************
  // divider counts 0..divider_act, so the ratio is divider_act + 1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_count_q <= RST_ZERO[W-1:0];
    end else if (reinit) begin
      div_count_q <= RST_ZERO[W-1:0];
    end else if (tick) begin
      div_count_q <= RST_ZERO[W-1:0];
    end else if (counter_enable_q) begin
      div_count_q <= W'(div_count_q + 1'b1);
    end
  end

  // counter: reinit first, then software load, then a divided step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_value_q <= RST_ZERO[W-1:0];
    end else if (reinit) begin
      count_value_q <= RST_ZERO[W-1:0];
    end else if (wr_count) begin
      count_value_q <= reg_wdata[W-1:0];
    end else if (wrap) begin
      count_value_q <= RST_ZERO[W-1:0];
    end else if (tick) begin
      count_value_q <= W'(count_value_q + 1'b1);
    end
  end

  // ****************************************************************
  // buffered divider and limit
  // ****************************************************************
  // writes land in the buffers; the divider never changes mid-period
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divider_buf_q <= RST_ZERO[W-1:0];
      wrap_buf_q <= RST_ZERO[W-1:0];
    end else begin
      if (wr_div) begin
        divider_buf_q <= reg_wdata[W-1:0];
      end
      if (wr_wrap) begin
        wrap_buf_q <= reg_wdata[W-1:0];
      end
    end
  end

  // active copies follow the buffers only on an update event
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divider_act_q <= RST_ZERO[W-1:0];
      wrap_shadow_q <= RST_ZERO[W-1:0];
    end else if (update_event) begin
      divider_act_q <= divider_buf_q;
      wrap_shadow_q <= wrap_buf_q;
    end
  end

  // ****************************************************************
  // interrupt status and mask
  // ****************************************************************
  // read clears, but an event in the read cycle survives
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status_q <= RST_IRQ;
    end else begin
      irq_status_q <= (rd_irq_status ? RST_IRQ : irq_status_q)
                      | {wrap, update_req && update_irq_enable_q};
    end
  end

  // mask register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_mask_q <= RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata[IRQ_W-1:0];
    end
  end

  // level interrupt while any unmasked event is pending
  assign irq = |(irq_status_q & irq_mask_q);

  // ****************************************************************
  // dma request and trigger output
  // ****************************************************************
  // one-cycle dma pulse per accepted update request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_request <= 1'b0;
    end else begin
      dma_request <= update_req && update_dma_enable_q;
    end
  end

  // trigger for the converter and cascaded timers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trigger_output <= 1'b0;
    end else begin
      unique case (master_output_select_q)
        MMS_RESET: trigger_output <= ug_fire;
        MMS_ENABLE: trigger_output <= counter_enable_q;
        MMS_UPDATE: trigger_output <= update_event;
        default: trigger_output <= 1'b0;  // compare modes absent here
      endcase
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // data stands only in the cycle after the strobe; unmapped read zero
  always_ff @(posedge clk) begin
    reg_rdata <= RST_ZERO;  // idle and reset value
    if (rst_n && reg_read) begin
      case (reg_addr)
        OFS_CONTROL_ONE: begin
          reg_rdata[BIT_COUNTER_ENABLE] <= counter_enable_q;
          reg_rdata[BIT_UPDATE_DISABLE] <= update_disable_q;
          reg_rdata[BIT_UPDATE_SOURCE] <= update_request_source_q;
          reg_rdata[BIT_SINGLE_PULSE] <= single_pulse_enable_q;
          reg_rdata[BIT_RELOAD_BUFFER] <= reload_buffer_enable_q;
        end
        OFS_CONTROL_TWO: reg_rdata[MMS_MSB:MMS_LSB] <= master_output_select_q;
        OFS_DMA_IRQ_EN: begin
          reg_rdata[BIT_UPDATE_IRQ_EN] <= update_irq_enable_q;
          reg_rdata[BIT_UPDATE_DMA_EN] <= update_dma_enable_q;
        end
        OFS_FLAGS: reg_rdata[BIT_UPDATE_FLAG] <= update_flag_q;
        OFS_IRQ_STATUS: reg_rdata[IRQ_W-1:0] <= irq_status_q;
        OFS_IRQ_MASK: reg_rdata[IRQ_W-1:0] <= irq_mask_q;
        OFS_COUNT: reg_rdata[W-1:0] <= count_value_q;
        OFS_DIVIDER: reg_rdata[W-1:0] <= divider_buf_q;
        OFS_WRAP: reg_rdata[W-1:0] <= wrap_buf_q;
        default: reg_rdata <= RST_ZERO;  // event_generate and holes
      endcase
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // wrap returns the count to zero
  property p_wrap_zero;
    wrap && !reinit && !wr_count |=> count_value_q == RST_ZERO[W-1:0];
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap to zero");
  // a tick below the limit adds exactly one
  property p_step_one;
    tick && !wrap && !reinit && !wr_count |=> count_value_q == W'($past(count_value_q) + 1'b1);
  endproperty
  a_step_one: assert property (p_step_one) else $error("count did not step by one");
  // with no tick the count holds
  property p_hold_no_tick;
    !tick && !reinit && !wr_count |=> $stable(count_value_q);
  endproperty
  a_hold_no_tick: assert property (p_hold_no_tick) else $error("count moved without tick");
  // a divider above zero never ticks on two clocks in a row
  property p_div_period;
    tick && !update_event |=> !tick || divider_act_q == RST_ZERO[W-1:0];
  endproperty
  a_div_period: assert property (p_div_period) else $error("back to back ticks");
  // update event loads both active copies
  property p_shadow_load;
    update_event |=> divider_act_q == $past(divider_buf_q) && wrap_shadow_q == $past(wrap_buf_q);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");
  // update disable: shadows never refresh
  property p_update_blocked;
    update_disable_q |=> $stable(divider_act_q) && $stable(wrap_shadow_q);
  endproperty
  a_update_blocked: assert property (p_update_blocked) else $error("update while disabled");
  // source select one: generate and slave updates leave flag and dma quiet
  property p_source_select;
    (ug_fire || slave_update) && update_request_source_q && !wrap && !wr_flags
      |=> $stable(update_flag_q) && !dma_request;
  endproperty
  a_source_select: assert property (p_source_select) else $error("non-wrap request");
  // single pulse stops the counter after the update
  property p_single_pulse;
    update_event && single_pulse_enable_q && !trigger_start && !wr_ctrl1 |=> !counter_enable_q;
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("single pulse kept running");
  // flag set one cycle after a request, and an irq follows when enabled
  sequence s_irq_request;
    update_req && update_irq_enable_q && irq_mask_q[EVT_UPDATE] && !wr_mask;
  endsequence
  sequence s_flag_and_irq;
    update_flag_q && irq;
  endsequence
  property p_flag_irq;
    s_irq_request |=> s_flag_and_irq;
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag or irq missing");

  // dma pulse only with its enable and a request
  property p_dma_gate;
    dma_request |-> $past(update_req) && $past(update_dma_enable_q);
  endproperty
  a_dma_gate: assert property (p_dma_gate) else $error("dma without cause");

  // update select copies the event to the trigger
  property p_trigger_update;
    master_output_select_q == MMS_UPDATE && update_event |=> trigger_output;
  endproperty
  a_trigger_update: assert property (p_trigger_update) else $error("trigger missed update");

  // generate bit clears counter and divider
  sequence s_generate;
    ug_fire && !update_disable_q;
  endsequence
  sequence s_cleared;
    count_value_q == RST_ZERO[W-1:0] && div_count_q == RST_ZERO[W-1:0];
  endsequence
  property p_generate_clear;
    s_generate |=> s_cleared;
  endproperty
  a_generate_clear: assert property (p_generate_clear) else $error("generate did not clear");

endmodule : basic_up_timer

// ### logic/basic_up_timer_pkg.sv
package basic_up_timer_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 8;   // byte address width of the register port
  localparam int unsigned DATA_W = 16;  // every register is one halfword

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h00;  // timer_control_one
  localparam logic [ADDR_W-1:0] OFS_CONTROL_TWO = 8'h04;  // timer_control_two
  localparam logic [ADDR_W-1:0] OFS_DMA_IRQ_EN = 8'h0c;   // dma_irq_enable
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h10;        // timer_flags
  localparam logic [ADDR_W-1:0] OFS_EVENT_GEN = 8'h14;    // event_generate
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h18;   // sticky events, read clears
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;     // mask, same layout
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h24;        // count_value
  localparam logic [ADDR_W-1:0] OFS_DIVIDER = 8'h28;      // clock_divider
  localparam logic [ADDR_W-1:0] OFS_WRAP = 8'h2c;         // wrap_limit

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned BIT_COUNTER_ENABLE = 0;   // timer_control_one
  localparam int unsigned BIT_UPDATE_DISABLE = 1;
  localparam int unsigned BIT_UPDATE_SOURCE = 2;
  localparam int unsigned BIT_SINGLE_PULSE = 3;
  localparam int unsigned BIT_RELOAD_BUFFER = 7;
  localparam int unsigned MMS_LSB = 4;              // timer_control_two, bits 6:4
  localparam int unsigned MMS_MSB = 6;
  localparam int unsigned BIT_UPDATE_IRQ_EN = 0;    // dma_irq_enable
  localparam int unsigned BIT_UPDATE_DMA_EN = 8;
  localparam int unsigned BIT_UPDATE_FLAG = 0;      // timer_flags
  localparam int unsigned BIT_UPDATE_GENERATE = 0;  // event_generate
  localparam int unsigned IRQ_W = 2;                // irq status / mask width
  localparam int unsigned EVT_UPDATE = 0;           // update request taken
  localparam int unsigned EVT_WRAP = 1;             // counter wrapped to zero

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0] RST_ZERO = 16'h0000;  // all registers clear
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;

  // ****************************************************************
  // master output select codes
  // ****************************************************************
  localparam logic [2:0] MMS_RESET = 3'h0;   // software update generate pulse
  localparam logic [2:0] MMS_ENABLE = 3'h1;  // counter enable level
  localparam logic [2:0] MMS_UPDATE = 3'h2;  // update event pulse

endpackage : basic_up_timer_pkg

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top import basic_up_timer_pkg::*; ;
  // ************************************************
  // stimulus and observed signals
  // ************************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;  // held low for six edges
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic slave_update = 1'b0;
  logic trigger_start = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic irq;
  logic dma_request;
  logic trigger_output;
  logic [DATA_W-1:0] exp_q[$];  // expected read data, oldest first
  logic rd_dly = 1'b0;  // a read was taken at the last edge
  int dma_cnt = 0;  // pulses counted on the one-cycle outputs
  int trig_cnt = 0;
  logic [15:0] lfsr = 16'h0023;
  int failures = 0;
  int checks_done = 0;
  logic [7:0] offs[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h24,
    8'h28, 8'h2c};  // 0x08 is unmapped

  always #2 clk = ~clk;

  basic_up_timer i_basic_up_timer (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .slave_update(slave_update), .trigger_start(trigger_start), .irq(irq),
    .dma_request(dma_request), .trigger_output(trigger_output));

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  // one-cycle write strobe, taken at the second edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  // read strobe; the monitor compares the data one cycle later
  task automatic rd(input logic [7:0] a, input logic [15:0] want);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    exp_q.push_back(want);
    @(posedge clk);
    reg_read <= 1'b0;
  endtask : rd

  task automatic pulse_in(input bit hw_start);
    @(posedge clk);
    if (hw_start) trigger_start <= 1'b1;
    else slave_update <= 1'b1;
    @(posedge clk);
    trigger_start <= 1'b0;
    slave_update <= 1'b0;
  endtask : pulse_in

  task automatic finish_test();
    repeat (3) @(posedge clk);
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // ************************************************
  // monitor: read data stands only in the cycle after the strobe
  // ************************************************
  always @(posedge clk) begin
    if (rd_dly) begin
      // an empty queue means a read the bench never issued
      if (exp_q.size() == 0) chk(reg_rdata, 16'hdead);
      else chk(reg_rdata, exp_q.pop_front());
    end
    rd_dly <= reg_read;
    if (dma_request === 1'b1) dma_cnt++;
    if (trigger_output === 1'b1) trig_cnt++;
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin : main
    int k;
    int t0;
    int d0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (offs[i]) rd(offs[i], 16'h0000);
    $display("test reset values end");
    for (k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      wr(OFS_DIVIDER, lfsr);
      rd(OFS_DIVIDER, lfsr);
      wr(OFS_WRAP, ~lfsr);
      rd(OFS_WRAP, ~lfsr);
      wr(OFS_COUNT, lfsr ^ 16'h5a5a);
      rd(OFS_COUNT, lfsr ^ 16'h5a5a);
    end
    $display("test readback end");
    // divide by four; a one-edge slip in start or stop keeps ten ticks
    wr(OFS_DIVIDER, 16'h0003);
    wr(OFS_WRAP, 16'hffff);
    wr(OFS_EVENT_GEN, 16'h0001);
    wr(OFS_CONTROL_ONE, 16'h0001);
    repeat (40) @(posedge clk);
    wr(OFS_CONTROL_ONE, 16'h0000);
    repeat (5) @(posedge clk);
    rd(OFS_COUNT, 16'h000a);
    rd(OFS_FLAGS, 16'h0001);
    chk(16'(trig_cnt), 16'h0001);
    $display("test divider end");
    wr(OFS_FLAGS, 16'h0000);
    rd(OFS_FLAGS, 16'h0000);
    wr(OFS_CONTROL_ONE, 16'h0002);
    wr(OFS_EVENT_GEN, 16'h0001);
    rd(OFS_FLAGS, 16'h0000);
    rd(OFS_COUNT, 16'h000a);
    wr(OFS_CONTROL_ONE, 16'h0004);
    wr(OFS_EVENT_GEN, 16'h0001);
    rd(OFS_FLAGS, 16'h0000);
    rd(OFS_COUNT, 16'h0000);
    wr(OFS_CONTROL_ONE, 16'h0000);
    pulse_in(1'b0);
    rd(OFS_FLAGS, 16'h0001);
    $display("test update sources end");
    // wrap at three with irq, dma and update trigger enabled
    wr(OFS_DIVIDER, 16'h0000);
    wr(OFS_EVENT_GEN, 16'h0001);
    wr(OFS_FLAGS, 16'h0000);
    wr(OFS_IRQ_MASK, 16'h0003);
    wr(OFS_DMA_IRQ_EN, 16'h0101);
    wr(OFS_CONTROL_TWO, 16'h0020);
    wr(OFS_WRAP, 16'h0003);
    rd(OFS_IRQ_STATUS, 16'h0000);
    t0 = trig_cnt;
    d0 = dma_cnt;
    wr(OFS_CONTROL_ONE, 16'h0001);
    k = 0;
    while (irq !== 1'b1 && k < 64) begin
      @(posedge clk);
      k++;
    end
    if (k == 64) begin
      failures++;
      finish_test();
    end
    wr(OFS_CONTROL_ONE, 16'h0000);
    rd(OFS_FLAGS, 16'h0001);
    rd(OFS_IRQ_STATUS, 16'h0003);
    @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    chk(16'(dma_cnt - d0), 16'h0001);
    chk(16'(trig_cnt - t0), 16'h0001);
    $display("test wrap irq end");
    wr(OFS_CONTROL_ONE, 16'h0009);
    repeat (10) @(posedge clk);
    rd(OFS_CONTROL_ONE, 16'h0008);
    rd(OFS_COUNT, 16'h0000);
    wr(OFS_CONTROL_ONE, 16'h0000);
    wr(OFS_CONTROL_TWO, 16'h0010);
    pulse_in(1'b1);
    repeat (2) @(posedge clk);
    chk({15'h0000, trigger_output}, 16'h0001);
    rd(OFS_CONTROL_ONE, 16'h0001);
    $display("test single pulse trigger end");
    // buffered limit must not act before the next update
    wr(OFS_CONTROL_ONE, 16'h0080);
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_WRAP, 16'hffff);
    wr(OFS_FLAGS, 16'h0000);
    wr(OFS_CONTROL_ONE, 16'h0081);
    repeat (10) @(posedge clk);
    rd(OFS_FLAGS, 16'h0001);
    $display("test reload buffer end");
    finish_test();
  end
endmodule : tb_top
